// >>> shared/mgmt_load_pkg.sv
package mgmt_load_pkg;

	// ==========================================================
	// Strap decode
	// ==========================================================
	// The four strap levels arrive from the level sensor as a code.
	typedef enum logic [1:0] {
		MODE_JTAG     = 2'h0,
		MODE_RESERVED = 2'h1,
		MODE_MASTER   = 2'h2,
		MODE_SLAVE    = 2'h3
	} mode_type;

	// ==========================================================
	// Master sequencer
	// ==========================================================
	typedef enum logic [3:0] {
		M_IDLE    = 4'h0,
		M_START   = 4'h1,
		M_ADDR    = 4'h2,
		M_ACK_IN  = 4'h3,
		M_DATA    = 4'h4,
		M_ACK_OUT = 4'h5,
		M_STOP    = 4'h6,
		M_DONE    = 4'h7,
		M_FAIL    = 4'h8
	} master_state_type;

	localparam int        CLK_PERIOD_NS  = 20;
	localparam int        BIT_QUARTER_NS = 2500;
	localparam int        QUARTER_CYCLES = BIT_QUARTER_NS / CLK_PERIOD_NS;
	localparam logic [1:0] PHASE_LAST    = 2'h3;
	localparam logic [1:0] PHASE_HIGH    = 2'h1;
	localparam logic [1:0] PHASE_SAMPLE  = 2'h2;
	localparam logic [2:0] BIT_MSB       = 3'h7;
	localparam logic [6:0] EEPROM_ADDR   = 7'h50;

	// ==========================================================
	// Slave registers
	// ==========================================================
	localparam logic [7:0] REG_INT_MASK  = 8'h00;
	localparam logic [7:0] REG_INT_CLEAR = 8'h01;
	localparam logic [7:0] INT_MASK_RST  = 8'h00;
	localparam logic [1:0] SLV_BYTE_ADDR = 2'h0;
	localparam logic [1:0] SLV_BYTE_REG  = 2'h1;
	localparam logic [1:0] SLV_BYTE_DATA = 2'h2;
	localparam logic [3:0] LINK_BITS     = 4'h8;

	typedef struct packed {
		logic       valid;
		logic [7:0] addr;
		logic [7:0] data;
	} cfg_write_type;

endpackage : mgmt_load_pkg

// >>> verilog/mgmt_mode_eeprom_load_ctrl.sv
// Summary of operation
// - Strap at lowest level selects boundary-scan mode and pin reuse.
// - Float selects master, high selects slave, resistive level is reserved.
// - In master mode a falling edge on the load request starts the EEPROM read.
// - Master mode: done goes low only after a successful complete load.
// - Slave mode: done output follows the request input level.
// - Slave mode: low request holds the bus logic and registers reset.
// - Interrupt pin pulls low while an enabled event is pending.
// - Software selects interrupt events through registers written over the bus.
// - Interrupt pin only sinks, allowing a shared wired-OR line.
// - Clock and data pins are open drain; clock received or driven low.
module mgmt_mode_eeprom_load_ctrl #(
	parameter int         IMAGE_BYTES = 16,
	parameter int         EVENTS      = 8,
	parameter logic [6:0] SLAVE_ADDR  = 7'h18
) (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic [1:0]                 mgmt_mode_strap,
	input  wire logic                       load_request_n,
	input  wire logic                       serial_mgmt_clock_pin,
	input  wire logic                       sda_in,
	input  wire logic [EVENTS-1:0]          event_in,
	output logic                            sda_out,
	output logic                            sda_oe,
	output logic                            scl_out,
	output logic                            scl_oe,
	output logic                            int_out,
	output logic                            int_oe,
	output logic                            all_done_n,
	output logic                            jtag_mode,
	output mgmt_load_pkg::cfg_write_type    cfg_write
);

	// ==========================================================
	// Pin synchronisers and strap capture
	// ==========================================================
	logic [1:0]             strap_meta;
	logic [1:0]             strap_sync;
	logic                   req_meta;
	logic                   req_sync;
	logic                   req_last;
	logic                   sda_meta;
	logic                   sda_sync;
	logic                   captured;
	mgmt_load_pkg::mode_type mode;

	// No reset on the strap flops: they fill while reset is held, so the
	// mode taken at the first edge after release is the real strap.
	always_ff @(posedge clk) begin
		strap_meta <= mgmt_mode_strap;
		strap_sync <= strap_meta;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			req_meta   <= 1'b1;
			req_sync   <= 1'b1;
			req_last   <= 1'b1;
			sda_meta   <= 1'b1;
			sda_sync   <= 1'b1;
		end else begin
			req_meta   <= load_request_n;
			req_sync   <= req_meta;
			req_last   <= req_sync;
			sda_meta   <= sda_in;
			sda_sync   <= sda_meta;
		end
	end

	// The strap is read once after release; later changes are ignored.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			captured  <= 1'b0;
			mode      <= mgmt_load_pkg::MODE_RESERVED;
			jtag_mode <= 1'b0;
		end else if (!captured) begin
			captured  <= 1'b1;
			mode      <= mgmt_load_pkg::mode_type'(strap_sync);
			jtag_mode <= (strap_sync == mgmt_load_pkg::MODE_JTAG);
		end
	end

	wire logic master     = captured && (mode == mgmt_load_pkg::MODE_MASTER);
	wire logic slave      = captured && (mode == mgmt_load_pkg::MODE_SLAVE);
	wire logic req_fall   = req_last && !req_sync;
	wire logic slave_hold = slave && !req_sync;

	// ==========================================================
	// Master EEPROM reader
	// ==========================================================
	mgmt_load_pkg::master_state_type state;
	logic [7:0]  div;
	logic [1:0]  phase;
	logic [2:0]  bit_idx;
	logic [7:0]  shreg;
	logic [7:0]  byte_cnt;
	wire  logic  tick      = (div == 8'(mgmt_load_pkg::QUARTER_CYCLES - 1));
	wire  logic  last_byte = (byte_cnt == 8'(IMAGE_BYTES - 1));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div   <= 8'h00;
			phase <= 2'h0;
		end else if (state == mgmt_load_pkg::M_IDLE || tick) begin
			div   <= 8'h00;
			phase <= (state == mgmt_load_pkg::M_IDLE) ? 2'h0 : phase + 2'h1;
		end else begin
			div <= div + 8'h01;
		end
	end

	// Clock and data are only ever pulled low; release lets the pull-up win.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state     <= mgmt_load_pkg::M_IDLE;
			bit_idx   <= 3'h0;
			shreg     <= 8'h00;
			byte_cnt  <= 8'h00;
			sda_oe    <= 1'b0;
			scl_oe    <= 1'b0;
			cfg_write <= '0;
		end else begin
			cfg_write.valid <= 1'b0;
			case (state)
			mgmt_load_pkg::M_IDLE, mgmt_load_pkg::M_FAIL: begin
				sda_oe <= 1'b0;
				scl_oe <= 1'b0;
				if (master && req_fall) begin
					state    <= mgmt_load_pkg::M_START;
					byte_cnt <= 8'h00;
				end
			end
			mgmt_load_pkg::M_START: if (tick) begin
				if (phase == mgmt_load_pkg::PHASE_HIGH)
					sda_oe <= 1'b1;
				if (phase == mgmt_load_pkg::PHASE_SAMPLE)
					scl_oe <= 1'b1;
				if (phase == mgmt_load_pkg::PHASE_LAST) begin
					state   <= mgmt_load_pkg::M_ADDR;
					bit_idx <= mgmt_load_pkg::BIT_MSB;
					shreg   <= {mgmt_load_pkg::EEPROM_ADDR, 1'b1};
				end
			end
			mgmt_load_pkg::M_ADDR: if (tick) begin
				if (phase == 2'h0)
					sda_oe <= !shreg[7];
				scl_oe <= !(phase == mgmt_load_pkg::PHASE_HIGH ||
					phase == mgmt_load_pkg::PHASE_SAMPLE);
				if (phase == mgmt_load_pkg::PHASE_LAST) begin
					shreg   <= {shreg[6:0], 1'b0};
					bit_idx <= bit_idx - 3'h1;
					if (bit_idx == 3'h0)
						state <= mgmt_load_pkg::M_ACK_IN;
				end
			end
			mgmt_load_pkg::M_ACK_IN: if (tick) begin
				sda_oe <= 1'b0;
				scl_oe <= !(phase == mgmt_load_pkg::PHASE_HIGH ||
					phase == mgmt_load_pkg::PHASE_SAMPLE);
				// A missing acknowledge ends the load as failed.
				if (phase == mgmt_load_pkg::PHASE_SAMPLE)
					shreg[0] <= sda_sync;
				if (phase == mgmt_load_pkg::PHASE_LAST) begin
					bit_idx <= mgmt_load_pkg::BIT_MSB;
					state   <= shreg[0] ? mgmt_load_pkg::M_STOP
						: mgmt_load_pkg::M_DATA;
				end
			end
			mgmt_load_pkg::M_DATA: if (tick) begin
				sda_oe <= 1'b0;
				scl_oe <= !(phase == mgmt_load_pkg::PHASE_HIGH ||
					phase == mgmt_load_pkg::PHASE_SAMPLE);
				if (phase == mgmt_load_pkg::PHASE_SAMPLE)
					shreg <= {shreg[6:0], sda_sync};
				if (phase == mgmt_load_pkg::PHASE_LAST) begin
					bit_idx <= bit_idx - 3'h1;
					if (bit_idx == 3'h0) begin
						state     <= mgmt_load_pkg::M_ACK_OUT;
						cfg_write <= '{1'b1, byte_cnt, shreg};
					end
				end
			end
			mgmt_load_pkg::M_ACK_OUT: if (tick) begin
				if (phase == 2'h0)
					sda_oe <= !last_byte;
				scl_oe <= !(phase == mgmt_load_pkg::PHASE_HIGH ||
					phase == mgmt_load_pkg::PHASE_SAMPLE);
				if (phase == mgmt_load_pkg::PHASE_LAST) begin
					byte_cnt <= byte_cnt + 8'h01;
					bit_idx  <= mgmt_load_pkg::BIT_MSB;
					shreg    <= 8'h00;
					state    <= last_byte ? mgmt_load_pkg::M_STOP
						: mgmt_load_pkg::M_DATA;
				end
			end
			mgmt_load_pkg::M_STOP: if (tick) begin
				if (phase == 2'h0)
					sda_oe <= 1'b1;
				if (phase == mgmt_load_pkg::PHASE_HIGH)
					scl_oe <= 1'b0;
				if (phase == mgmt_load_pkg::PHASE_SAMPLE)
					sda_oe <= 1'b0;
				if (phase == mgmt_load_pkg::PHASE_LAST)
					state <= (byte_cnt == 8'(IMAGE_BYTES))
						? mgmt_load_pkg::M_DONE : mgmt_load_pkg::M_FAIL;
			end
			mgmt_load_pkg::M_DONE: begin
				sda_oe <= 1'b0;
				scl_oe <= 1'b0;
			end
			default: state <= mgmt_load_pkg::M_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Done output and open-drain levels
	// ==========================================================
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			all_done_n <= 1'b1;
			sda_out    <= 1'b0;
			scl_out    <= 1'b0;
			int_out    <= 1'b0;
		end else begin
			if (master)
				all_done_n <= (state != mgmt_load_pkg::M_DONE);
			else if (slave)
				all_done_n <= req_sync;
			else
				all_done_n <= 1'b1;
			sda_out <= 1'b0;
			scl_out <= 1'b0;
			int_out <= 1'b0;
		end
	end

	// ==========================================================
	// Slave receive on the link clock
	// ==========================================================
	// The link clock stops between frames, so its counter is cleared
	// from the system side while the slave is held.
	logic       link_rst_n;
	logic [3:0] link_cnt;
	logic [7:0] link_shift;
	logic [7:0] link_byte;
	logic       link_toggle;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			link_rst_n <= 1'b0;
		else
			link_rst_n <= slave && !slave_hold;
	end

	always_ff @(posedge serial_mgmt_clock_pin or negedge link_rst_n) begin
		if (!link_rst_n) begin
			link_cnt    <= 4'h0;
			link_shift  <= 8'h00;
			link_byte   <= 8'h00;
			link_toggle <= 1'b0;
		end else if (link_cnt == mgmt_load_pkg::LINK_BITS) begin
			link_cnt <= 4'h0;
		end else begin
			link_shift <= {link_shift[6:0], sda_in};
			link_cnt   <= link_cnt + 4'h1;
			if (link_cnt == mgmt_load_pkg::LINK_BITS - 4'h1) begin
				link_byte   <= {link_shift[6:0], sda_in};
				link_toggle <= !link_toggle;
			end
		end
	end

	// ==========================================================
	// Interrupt registers
	// ==========================================================
	logic              tog_meta;
	logic              tog_sync;
	logic              tog_last;
	logic [1:0]        slv_idx;
	logic              addr_ok;
	logic [7:0]        reg_sel;
	logic [EVENTS-1:0] int_mask;
	logic [EVENTS-1:0] pending;
	logic [EVENTS-1:0] clr;
	wire  logic        byte_in = tog_sync != tog_last;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tog_meta <= 1'b0;
			tog_sync <= 1'b0;
			tog_last <= 1'b0;
		end else begin
			tog_meta <= link_toggle;
			tog_sync <= tog_meta;
			tog_last <= tog_sync;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slv_idx  <= mgmt_load_pkg::SLV_BYTE_ADDR;
			addr_ok  <= 1'b0;
			reg_sel  <= 8'h00;
			int_mask <= EVENTS'(mgmt_load_pkg::INT_MASK_RST);
			clr      <= '0;
		end else if (slave_hold || !link_rst_n) begin
			slv_idx  <= mgmt_load_pkg::SLV_BYTE_ADDR;
			int_mask <= EVENTS'(mgmt_load_pkg::INT_MASK_RST);
			clr      <= '0;
		end else begin
			clr <= '0;
			if (byte_in) begin
				case (slv_idx)
				mgmt_load_pkg::SLV_BYTE_ADDR: begin
					addr_ok <= (link_byte == {SLAVE_ADDR, 1'b0});
					slv_idx <= mgmt_load_pkg::SLV_BYTE_REG;
				end
				mgmt_load_pkg::SLV_BYTE_REG: begin
					reg_sel <= link_byte;
					slv_idx <= mgmt_load_pkg::SLV_BYTE_DATA;
				end
				default: begin
					slv_idx <= mgmt_load_pkg::SLV_BYTE_ADDR;
					if (addr_ok && reg_sel == mgmt_load_pkg::REG_INT_MASK)
						int_mask <= EVENTS'(link_byte);
					if (addr_ok && reg_sel == mgmt_load_pkg::REG_INT_CLEAR)
						clr <= EVENTS'(link_byte);
				end
				endcase
			end
		end
	end

	// A new event in the clearing cycle stays pending.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pending <= '0;
			int_oe  <= 1'b0;
		end else begin
			pending <= slave_hold ? '0 : ((pending & ~clr) | event_in);
			int_oe  <= |(pending & int_mask);
		end
	end

	// ==========================================================
	// Checks
	// ==========================================================
	AST_JTAG_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
		captured |-> (jtag_mode == (mode == mgmt_load_pkg::MODE_JTAG)))
		else $error("jtag flag disagrees with strap");
	AST_RESERVED_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
		(captured && mode == mgmt_load_pkg::MODE_RESERVED) |=> all_done_n && !scl_oe)
		else $error("reserved mode not quiet");
	AST_LOAD_START: assert property (@(posedge clk) disable iff (!rst_n)
		(master && req_fall && state == mgmt_load_pkg::M_IDLE)
		|=> state == mgmt_load_pkg::M_START)
		else $error("load did not start");
	AST_DONE_AFTER_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
		(master && !all_done_n) |-> $past(state) == mgmt_load_pkg::M_DONE)
		else $error("done low without complete load");
	AST_SLAVE_FOLLOW: assert property (@(posedge clk) disable iff (!rst_n)
		slave ##1 slave |-> all_done_n == $past(req_sync))
		else $error("done does not follow request");
	AST_SLAVE_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		slave_hold |=> (pending == '0) && (int_mask == '0) ##1 !int_oe)
		else $error("slave hold did not reset");
	AST_INT_DRIVE: assert property (@(posedge clk) disable iff (!rst_n)
		|(pending & int_mask) |=> int_oe)
		else $error("enabled event not signalled");
	AST_INT_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
		(pending[0] && !clr[0] && !slave_hold) |=> pending[0])
		else $error("pending event lost");
	AST_SINK_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
		##1 !int_out && !sda_out && !scl_out)
		else $error("open-drain line driven high");
	AST_MASTER_CLOCK: assert property (@(posedge clk) disable iff (!rst_n)
		scl_oe |-> master)
		else $error("clock driven outside master mode");

endmodule : mgmt_mode_eeprom_load_ctrl

// >>> verification/eeprom_partner_model.sv
module eeprom_partner_model #(
	parameter logic [6:0] DEV_ADDR = 7'h50
) (
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic refuse,
	output logic      sda_low
);
	timeunit 1ns;
	timeprecision 1ns;
	int         bit_count;
	int         byte_count;
	logic       active;
	logic [7:0] shift;
	logic [7:0] out_byte;

	initial begin
		bit_count = 0;
		byte_count = 0;
		active = 1'b0;
		shift = 8'h00;
		sda_low = 1'b0;
	end

	// ==========================================================
	// Framing
	// ==========================================================
	// A start restarts framing; a fall while the clock is low is data.
	always @(negedge sda) begin
		if (scl === 1'b1) begin
			bit_count = 0;
			byte_count = 0;
			active = 1'b0;
		end
	end

	// A high acknowledge slot from the reader ends the image.
	always @(posedge scl) begin
		if (bit_count < 8)
			shift = {shift[6:0], sda};
		if (bit_count == 8 && byte_count > 0 && sda === 1'b1)
			active = 1'b0;
		bit_count++;
	end

	// Released data reads high through the pull-up, never a stale value.
	always @(negedge scl) begin
		if (bit_count == 9) begin
			bit_count = 0;
			byte_count++;
		end
		out_byte = 8'h3C + 8'(byte_count - 1) * 8'h11;
		if (bit_count == 8 && byte_count == 0) begin
			active = !refuse && shift == {DEV_ADDR, 1'b1};
			sda_low = active;
		end else if (bit_count < 8 && byte_count > 0 && active)
			sda_low = !out_byte[7 - bit_count];
		else
			sda_low = 1'b0;
	end
endmodule : eeprom_partner_model

// >>> verification/test_mgmt_mode_eeprom_load_ctrl.sv
`define CHECK(nm, ex, gt) begin \
	comparisons++; \
	if ((gt) !== (ex)) begin \
		fails++; \
		$display("CHECK FAILED %s expected %0h seen %0h", nm, ex, gt); \
	end \
end

module test_mgmt_mode_eeprom_load_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int         BYTES = 2;
	localparam logic [6:0] SADDR = 7'h18;
	logic                         clk;
	logic                         rst_n;
	logic [1:0]                   strap;
	logic                         req_n;
	logic                         host_scl;
	logic                         host_sda_low;
	logic                         refuse;
	logic [7:0]                   event_in;
	logic                         sda_out;
	logic                         sda_oe;
	logic                         scl_out;
	logic                         scl_oe;
	logic                         int_out;
	logic                         int_oe;
	logic                         done_n;
	logic                         jtag_mode;
	logic                         eep_sda_low;
	logic                         drove_high;
	mgmt_load_pkg::cfg_write_type cfg_write;
	mgmt_load_pkg::cfg_write_type seen_q[$];
	int                           fails;
	int                           comparisons;
	wire                          scl_wire;
	wire                          sda_wire;

	// Both lines are wired-AND with a pull-up.
	assign scl_wire = host_scl & !scl_oe;
	assign sda_wire = !(sda_oe | eep_sda_low | host_sda_low);

	mgmt_mode_eeprom_load_ctrl #(
		.IMAGE_BYTES(BYTES),
		.EVENTS     (8),
		.SLAVE_ADDR (SADDR)
	) mgmt_mode_eeprom_load_ctrl_inst (
		.clk                  (clk),
		.rst_n                (rst_n),
		.mgmt_mode_strap      (strap),
		.load_request_n       (req_n),
		.serial_mgmt_clock_pin(scl_wire),
		.sda_in               (sda_wire),
		.event_in             (event_in),
		.sda_out              (sda_out),
		.sda_oe               (sda_oe),
		.scl_out              (scl_out),
		.scl_oe               (scl_oe),
		.int_out              (int_out),
		.int_oe               (int_oe),
		.all_done_n           (done_n),
		.jtag_mode            (jtag_mode),
		.cfg_write            (cfg_write)
	);

	eeprom_partner_model eeprom_partner_model_inst (
		.scl    (scl_wire),
		.sda    (sda_wire),
		.refuse (refuse),
		.sda_low(eep_sda_low)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = !clk;
	end

	always @(posedge clk) begin
		if (cfg_write.valid === 1'b1)
			seen_q.push_back(cfg_write);
		if (rst_n && (int_out !== 1'b0 || sda_out !== 1'b0 || scl_out !== 1'b0))
			drove_high <= 1'b1;
	end

	task automatic summarize();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize

	task automatic clks(input int n);
		repeat (n) @(posedge clk);
	endtask : clks

	// The strap is only captured after a reset, so each mode starts here.
	task automatic start(input logic [1:0] mode);
		@(posedge clk);
		rst_n <= 1'b0;
		strap <= mode;
		req_n <= 1'b1;
		clks(16);
		rst_n <= 1'b1;
		clks(4);
	endtask : start

	// The link clock idles high and each bit is one fall and one rise, so
	// a frame gives exactly nine rising edges per byte and none between.
	task automatic link_byte(input logic [7:0] b);
		for (int i = 8; i >= 0; i--) begin
			host_scl = 1'b0;
			#8 host_sda_low = (i > 0) ? !b[i - 1] : 1'b0;
			#8 host_scl = 1'b1;
			#16;
		end
	endtask : link_byte

	task automatic link_write(input logic [7:0] r, input logic [7:0] d);
		link_byte({SADDR, 1'b0});
		link_byte(r);
		link_byte(d);
		clks(10);
	endtask : link_write

	task automatic test_strap_modes();
		start(2'h0);
		`CHECK("jtag mode", 1'b1, jtag_mode)
		start(2'h1);
		@(posedge clk) req_n <= 1'b0;
		clks(2000);
		`CHECK("reserved jtag", 1'b0, jtag_mode)
		`CHECK("reserved done", 1'b1, done_n)
		`CHECK("reserved bus", 1'b0, scl_oe)
		$display("test strap modes done");
	endtask : test_strap_modes

	task automatic test_master();
		int n;
		start(2'h2);
		refuse = 1'b1;
		seen_q.delete();
		@(posedge clk) req_n <= 1'b0;
		clks(8000);
		`CHECK("refused done", 1'b1, done_n)
		`CHECK("refused bytes", 0, seen_q.size())
		refuse = 1'b0;
		@(posedge clk) req_n <= 1'b1;
		clks(8);
		req_n <= 1'b0;
		n = 0;
		while (done_n !== 1'b0 && n < 40000) begin
			@(posedge clk);
			n++;
		end
		`CHECK("load done", 1'b0, done_n)
		// A load that never finishes is a hang: report at once.
		if (done_n !== 1'b0)
			summarize();
		`CHECK("load bytes", BYTES, seen_q.size())
		for (int i = 0; i < BYTES && i < seen_q.size(); i++) begin
			`CHECK("byte addr", 8'(i), seen_q[i].addr)
			`CHECK("byte data", 8'h3C + 8'(i) * 8'h11, seen_q[i].data)
		end
		clks(3000);
		`CHECK("held done", 1'b0, done_n)
		`CHECK("held bytes", BYTES, seen_q.size())
		`CHECK("open drain", 1'b0, drove_high)
		$display("test master done");
	endtask : test_master

	task automatic pulse(input logic [7:0] ev);
		@(posedge clk) event_in <= ev;
		@(posedge clk) event_in <= 8'h00;
		clks(5);
	endtask : pulse

	task automatic test_slave();
		start(2'h3);
		`CHECK("follow high", 1'b1, done_n)
		@(posedge clk) req_n <= 1'b0;
		clks(6);
		`CHECK("follow low", 1'b0, done_n)
		@(posedge clk) req_n <= 1'b1;
		clks(6);
		pulse(8'h01);
		`CHECK("mask reset", 1'b0, int_oe)
		link_write(8'h00, 8'h01);
		`CHECK("old pending", 1'b1, int_oe)
		link_write(8'h01, 8'h01);
		pulse(8'h02);
		`CHECK("masked event", 1'b0, int_oe)
		pulse(8'h01);
		`CHECK("enabled event", 1'b1, int_oe)
		clks(50);
		`CHECK("stays pending", 1'b1, int_oe)
		link_write(8'h01, 8'h01);
		`CHECK("cleared", 1'b0, int_oe)
		pulse(8'h01);
		@(posedge clk) req_n <= 1'b0;
		clks(6);
		`CHECK("hold clears", 1'b0, int_oe)
		@(posedge clk) req_n <= 1'b1;
		clks(6);
		pulse(8'h01);
		`CHECK("hold mask", 1'b0, int_oe)
		`CHECK("int sink", 1'b0, drove_high)
		$display("test slave done");
	endtask : test_slave

	initial begin
		rst_n = 1'b0;
		strap = 2'h3;
		req_n = 1'b1;
		host_scl = 1'b1;
		host_sda_low = 1'b0;
		refuse = 1'b0;
		event_in = 8'h00;
		drove_high = 1'b0;
		fails = 0;
		comparisons = 0;
		test_strap_modes();
		test_master();
		test_slave();
		summarize();
	end
endmodule : test_mgmt_mode_eeprom_load_ctrl
